/* File: hw/rwcm_regs.vh */
// register map, field positions and timing counts of the reset and watchdog block
`ifndef RWCM_REGS_VH
`define RWCM_REGS_VH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define RWCM_AW              13
`define RWCM_SERVICE_ADDR    13'h001D
`define RWCM_CONTROL_ADDR    13'h001E
`define RWCM_FIXED_ADDR      13'h1FF0

// ----------------------------------------------------------------
// service values and control fields
// ----------------------------------------------------------------
`define RWCM_SERVICE_ARM     8'h55
`define RWCM_SERVICE_FIRE    8'hAA
`define RWCM_CTL_FLAG        4
`define RWCM_CTL_CME         3
`define RWCM_CTL_PEN         2
`define RWCM_CTL_SELHI       1
`define RWCM_CTL_SELLO       0
`define RWCM_FIXED_CLR_BIT   0
`define RWCM_SEL_2P15        2'h0
`define RWCM_SEL_2P17        2'h1
`define RWCM_SEL_2P19        2'h2
`define RWCM_SEL_2P21        2'h3

// ----------------------------------------------------------------
// reset sequence timing, in internal cycles
// ----------------------------------------------------------------
`define RWCM_POR_CYC         12'hFE0
`define RWCM_SAMPLE_CYC      12'h006
`define RWCM_PIN_PULSE       12'h004
`define RWCM_RST_MIN         12'h008

// ----------------------------------------------------------------
// sequencer states
// ----------------------------------------------------------------
`define RWCM_ST_POR          2'h0
`define RWCM_ST_RST          2'h1
`define RWCM_ST_RUN          2'h2

`endif

/* File: hw/rwcm_top.v */
// reset merge, power-on delay, two watchdogs and clock monitor
//
// Contract
// - any reset aborts, reinitialises, refetches vector
// - five sources merge into one reset
// - power-up holds reset for 4064 cycles
// - pin still low after delay extends reset
// - pin low 1.5 cycles requests reset
// - pin sampled at cycle six classifies reset
// - enabled watchdog expiry resets; service restarts
// - other accesses allowed between service writes
// - flag set by timeout/monitor, read clears
// - monitor enable always writable, reset clears
// - enabled monitor sets flag, forces reset
// - slow clock: four cycles; absent: hold
// - watchdog enable written once, reset clears
// - two-bit selector picks 2^15..2^21 period
// - upper three control bits read zero
// - both watchdogs run together, either resets
// - fixed watchdog period 262144 oscillator cycles
// - fixed watchdog only when option set
// - fixed service write zero bit0; read option
// - fixed watchdog off in bootloader mode
// - stop with monitor enabled resets device
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "rwcm_regs.vh"

module rwcm_top #(
  parameter [21:0] PWD_TO_2P15 = 22'h008000,
  parameter [21:0] PWD_TO_2P17 = 22'h020000,
  parameter [21:0] PWD_TO_2P19 = 22'h080000,
  parameter [21:0] PWD_TO_2P21 = 22'h200000,
  // 262144 oscillator cycles at two oscillator cycles per bus cycle
  parameter [21:0] FWD_TO      = 22'h020000
) (
  input  wire                 clk,
  input  wire                 reset_n,
  input  wire [`RWCM_AW-1:0]  reg_addr,
  input  wire [7:0]           reg_wdata,
  input  wire                 reg_wr,
  input  wire                 reg_rd,
  output reg  [7:0]           reg_rdata,
  input  wire                 rst_pin_i,
  output wire                 rst_pin_o,
  output reg                  rst_pin_oe,
  input  wire                 fixed_watchdog_option,
  input  wire [7:0]           option_byte_one,
  input  wire                 bootloader_mode,
  input  wire                 clock_slow,
  input  wire                 clock_absent,
  input  wire                 stop_req,
  output reg                  sys_reset,
  output reg                  reset_external
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg  [1:0]  state_r;
  reg  [1:0]  state_nxt;
  reg  [11:0] seq_cnt_r;
  reg  [11:0] seq_cnt_nxt;
  reg         int_src_r;
  reg         int_src_nxt;
  reg         abs_hold_r;
  reg         abs_hold_nxt;
  reg         oe_nxt;
  reg         ext_nxt;

  reg         pin_m_r;
  reg         pin_s_r;
  reg         slow_m_r;
  reg         slow_s_r;
  reg         slow_d_r;
  reg         abs_m_r;
  reg         abs_s_r;
  reg         opt_m_r;
  reg         opt_s_r;
  reg         boot_m_r;
  reg         boot_s_r;

  reg         clock_monitor_enable;
  reg         prog_watchdog_enable;
  reg  [1:0]  timeout_select;
  reg         ctl_locked_r;
  reg         watchdog_reset_flag;
  reg         armed_r;
  reg  [21:0] pwd_cnt_r;
  reg  [21:0] fwd_cnt_r;
  reg  [21:0] pwd_limit;
  reg  [7:0]  ctl_value;
  reg  [7:0]  rdata_nxt;

  wire        running;
  wire        soft_clr;
  wire        wr_service;
  wire        wr_control;
  wire        wr_fixed;
  wire        rd_control;
  wire        pwd_restart;
  wire        fwd_active;
  wire        fwd_service;
  wire        pwd_to;
  wire        fwd_to;
  wire        cm_slow_evt;
  wire        cm_abs_evt;
  wire        cm_stop_evt;
  wire        cm_evt;
  wire        src_int;
  wire        src_ext;

  // pin is open drain: only ever pulled low
  assign rst_pin_o = 1'b0;

  // ----------------------------------------------------------------
  // synchronisers for pins and asynchronous indications
  // ----------------------------------------------------------------
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_m_r  <= 1'b1;
      pin_s_r  <= 1'b1;
      slow_m_r <= 1'b0;
      slow_s_r <= 1'b0;
      slow_d_r <= 1'b0;
      abs_m_r  <= 1'b0;
      abs_s_r  <= 1'b0;
      opt_m_r  <= 1'b0;
      opt_s_r  <= 1'b0;
      boot_m_r <= 1'b0;
      boot_s_r <= 1'b0;
    end
    else
    begin
      pin_m_r  <= rst_pin_i;
      pin_s_r  <= pin_m_r;
      slow_m_r <= clock_slow;
      slow_s_r <= slow_m_r;
      slow_d_r <= slow_s_r;
      abs_m_r  <= clock_absent;
      abs_s_r  <= abs_m_r;
      opt_m_r  <= fixed_watchdog_option;
      opt_s_r  <= opt_m_r;
      boot_m_r <= bootloader_mode;
      boot_s_r <= boot_m_r;
    end
  end

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  assign running    = (state_r == `RWCM_ST_RUN);
  assign soft_clr   = ~running;
  assign wr_service = reg_wr & (reg_addr == `RWCM_SERVICE_ADDR);
  assign wr_control = reg_wr & (reg_addr == `RWCM_CONTROL_ADDR);
  assign wr_fixed   = reg_wr & (reg_addr == `RWCM_FIXED_ADDR);
  assign rd_control = reg_rd & (reg_addr == `RWCM_CONTROL_ADDR);

  // ----------------------------------------------------------------
  // clock monitor
  // ----------------------------------------------------------------
  // slow clock single event
  assign cm_slow_evt = clock_monitor_enable & slow_s_r & ~slow_d_r;
  assign cm_abs_evt  = clock_monitor_enable & abs_s_r;
  assign cm_stop_evt = clock_monitor_enable & stop_req;
  assign cm_evt      = running & (cm_slow_evt | cm_abs_evt | cm_stop_evt);

  // ----------------------------------------------------------------
  // programmable watchdog
  // ----------------------------------------------------------------
  // period from selector
  always @*
  begin
    case (timeout_select)
      `RWCM_SEL_2P15: pwd_limit = PWD_TO_2P15;
      `RWCM_SEL_2P17: pwd_limit = PWD_TO_2P17;
      `RWCM_SEL_2P19: pwd_limit = PWD_TO_2P19;
      `RWCM_SEL_2P21: pwd_limit = PWD_TO_2P21;
      default:        pwd_limit = PWD_TO_2P15;
    endcase
  end

  assign pwd_restart = wr_service & (reg_wdata == `RWCM_SERVICE_FIRE) & armed_r;
  assign pwd_to = running & prog_watchdog_enable & (pwd_cnt_r == pwd_limit - 22'h000001);

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      armed_r <= 1'b0;
    else if (soft_clr | pwd_restart)
      armed_r <= 1'b0;
    else if (wr_service & (reg_wdata == `RWCM_SERVICE_ARM))
      armed_r <= 1'b1;
  end

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      pwd_cnt_r <= 22'h000000;
    else if (soft_clr | pwd_restart)
      pwd_cnt_r <= 22'h000000;
    else if (prog_watchdog_enable)
      pwd_cnt_r <= pwd_cnt_r + 22'h000001;
  end

  // ----------------------------------------------------------------
  // fixed watchdog
  // ----------------------------------------------------------------
  // option bit gates it
  assign fwd_active  = opt_s_r & ~boot_s_r;
  assign fwd_service = wr_fixed & ~reg_wdata[`RWCM_FIXED_CLR_BIT];
  assign fwd_to = running & fwd_active & (fwd_cnt_r == FWD_TO - 22'h000001);

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      fwd_cnt_r <= 22'h000000;
    else if (soft_clr | ~fwd_active | fwd_service)
      fwd_cnt_r <= 22'h000000;
    else
      fwd_cnt_r <= fwd_cnt_r + 22'h000001;
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      clock_monitor_enable <= 1'b0;
      prog_watchdog_enable <= 1'b0;
      timeout_select       <= `RWCM_SEL_2P15;
      ctl_locked_r         <= 1'b0;
    end
    else if (soft_clr)
    begin
      clock_monitor_enable <= 1'b0;
      prog_watchdog_enable <= 1'b0;
      timeout_select       <= `RWCM_SEL_2P15;
      ctl_locked_r         <= 1'b0;
    end
    else if (wr_control)
    begin
      clock_monitor_enable <= reg_wdata[`RWCM_CTL_CME];
      ctl_locked_r         <= 1'b1;
      if (!ctl_locked_r)
      begin
        prog_watchdog_enable <= reg_wdata[`RWCM_CTL_PEN];
        timeout_select       <= {reg_wdata[`RWCM_CTL_SELHI], reg_wdata[`RWCM_CTL_SELLO]};
      end
    end
  end

  // flag survives internal resets so software can see the cause
  // set wins over read clear
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      watchdog_reset_flag <= 1'b0;
    else if (pwd_to | cm_evt)
      watchdog_reset_flag <= 1'b1;
    else if (rd_control)
      watchdog_reset_flag <= 1'b0;
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always @*
  begin
    ctl_value = 8'h00;
    ctl_value[`RWCM_CTL_FLAG]  = watchdog_reset_flag;
    ctl_value[`RWCM_CTL_CME]   = clock_monitor_enable;
    ctl_value[`RWCM_CTL_PEN]   = prog_watchdog_enable;
    ctl_value[`RWCM_CTL_SELHI] = timeout_select[1];
    ctl_value[`RWCM_CTL_SELLO] = timeout_select[0];
    rdata_nxt = 8'h00;
    if (reg_rd)
    begin
      case (reg_addr)
        `RWCM_CONTROL_ADDR: rdata_nxt = ctl_value;
        `RWCM_FIXED_ADDR:   rdata_nxt = option_byte_one;
        default:            rdata_nxt = 8'h00;
      endcase
    end
  end

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= rdata_nxt;
  end

  // ----------------------------------------------------------------
  // reset sequencer
  // ----------------------------------------------------------------
  // merged internal sources
  assign src_int = pwd_to | fwd_to | cm_evt;
  assign src_ext = ~pin_s_r;

  always @*
  begin
    state_nxt    = state_r;
    seq_cnt_nxt  = seq_cnt_r;
    int_src_nxt  = int_src_r;
    abs_hold_nxt = abs_hold_r;
    oe_nxt       = 1'b0;
    ext_nxt      = reset_external;
    case (state_r)
      `RWCM_ST_POR:
      begin
        if (seq_cnt_r != `RWCM_POR_CYC)
          seq_cnt_nxt = seq_cnt_r + 12'h001;
        else if (pin_s_r)
          state_nxt = `RWCM_ST_RUN;
      end
      `RWCM_ST_RUN:
      begin
        if (src_int | src_ext)
        begin
          state_nxt    = `RWCM_ST_RST;
          seq_cnt_nxt  = 12'h000;
          int_src_nxt  = src_int;
          abs_hold_nxt = cm_abs_evt;
          oe_nxt       = src_int;
        end
      end
      `RWCM_ST_RST:
      begin
        if (seq_cnt_r != `RWCM_RST_MIN)
          seq_cnt_nxt = seq_cnt_r + 12'h001;
        if (abs_hold_r & ~abs_s_r)
          abs_hold_nxt = 1'b0;
        // four cycles or until clock returns
        oe_nxt = (int_src_r & (seq_cnt_r + 12'h001 < `RWCM_PIN_PULSE)) |
                 (abs_hold_r & abs_s_r);
        // relies on external low and fast rise
        if (seq_cnt_r == `RWCM_SAMPLE_CYC)
          ext_nxt = ~pin_s_r & ~abs_hold_r;
        if ((seq_cnt_r == `RWCM_RST_MIN) & pin_s_r & ~abs_hold_r & ~rst_pin_oe)
          state_nxt = `RWCM_ST_RUN;
      end
      default:
      begin
        state_nxt   = `RWCM_ST_POR;
        seq_cnt_nxt = 12'h000;
      end
    endcase
  end

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r        <= `RWCM_ST_POR;
      seq_cnt_r      <= 12'h000;
      int_src_r      <= 1'b0;
      abs_hold_r     <= 1'b0;
      rst_pin_oe     <= 1'b0;
      reset_external <= 1'b0;
      sys_reset      <= 1'b1;
    end
    else
    begin
      state_r        <= state_nxt;
      seq_cnt_r      <= seq_cnt_nxt;
      int_src_r      <= int_src_nxt;
      abs_hold_r     <= abs_hold_nxt;
      rst_pin_oe     <= oe_nxt;
      reset_external <= ext_nxt;
      sys_reset      <= (state_nxt != `RWCM_ST_RUN);
    end
  end

endmodule // rwcm_top

`default_nettype wire

/* File: testbench/rwcm_checker.sv */
// port assertions for the reset and watchdog block
`timescale 1ns/1ns
`default_nettype none
`include "rwcm_regs.vh"
module rwcm_checker (
  input wire logic                clk,
  input wire logic                reset_n,
  input wire logic [`RWCM_AW-1:0] reg_addr,
  input wire logic                reg_rd,
  input wire logic [7:0]          reg_rdata,
  input wire logic                rst_pin_i,
  input wire logic                rst_pin_oe,
  input wire logic [7:0]          option_byte_one,
  input wire logic                clock_absent,
  input wire logic                sys_reset,
  input wire logic                reset_external
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  unused_bits_zero_a: assert property (
    $past(reg_rd) && $past(reg_addr) == `RWCM_CONTROL_ADDR |-> reg_rdata[7:5] == 3'h0)
    else $error("unused control bits read nonzero");
  option_read_a: assert property (
    $past(reg_rd) && !$past(sys_reset) && $past(reg_addr) == `RWCM_FIXED_ADDR
    |-> reg_rdata == $past(option_byte_one))
    else $error("option byte read wrong");
  pin_pulse_four_a: assert property (
    $rose(rst_pin_oe) && !clock_absent |-> rst_pin_oe [*4] ##1 !rst_pin_oe)
    else $error("pin drive not four cycles");
  drive_in_reset_a: assert property (
    rst_pin_oe |-> sys_reset)
    else $error("pin driven outside reset");
  reset_min_len_a: assert property (
    $rose(sys_reset) |-> sys_reset [*8])
    else $error("reset shorter than eight cycles");
  pin_low_resets_a: assert property (
    (!sys_reset && !rst_pin_i) [*3] |-> ##[0:2] sys_reset)
    else $error("low pin not taken as reset");
  pin_holds_reset_a: assert property (
    sys_reset && !rst_pin_i && !$past(rst_pin_i) |=> sys_reset)
    else $error("reset released with pin low");
  internal_class_a: assert property (
    $rose(rst_pin_oe) && !clock_absent |-> ##10 !reset_external)
    else $error("internal reset classed external");
endmodule // rwcm_checker

bind rwcm_top rwcm_checker i_rwcm_checker (
  .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .rst_pin_i(rst_pin_i), .rst_pin_oe(rst_pin_oe),
  .option_byte_one(option_byte_one), .clock_absent(clock_absent),
  .sys_reset(sys_reset), .reset_external(reset_external));
`default_nettype wire

/* File: testbench/rwcm_pin_model.sv */
// reset pin model: pull-up resistor plus an external open-drain driver
`timescale 1ns/1ns
`default_nettype none
module rwcm_pin_model (
  input  wire logic clk,
  input  wire logic dev_oe,
  output wire logic pin
);
  logic ext_low_r;
  initial ext_low_r = 1'b0;
  assign pin = !(dev_oe || ext_low_r);
  task automatic drive_low(input int n);
    @(posedge clk);
    ext_low_r <= 1'b1;
    repeat (n) @(posedge clk);
    ext_low_r <= 1'b0;
  endtask
  task automatic hold(input logic v);
    @(posedge clk);
    ext_low_r <= v;
  endtask
endmodule // rwcm_pin_model
`default_nettype wire

/* File: testbench/rwcm_top_tb.sv */
// self-checking bench for the reset and watchdog block
`timescale 1ns/1ns
`default_nettype none
`include "rwcm_regs.vh"
module rwcm_top_tb;
  logic                clk;
  logic                reset_n;
  logic [`RWCM_AW-1:0] reg_addr;
  logic [7:0]          reg_wdata, reg_rdata;
  logic                reg_wr, reg_rd, rst_pin, rst_pin_oe, rst_pin_d, fwd_opt, boot;
  logic [7:0]          opt_byte;
  logic                clk_slow, clk_absent, stop_req, sys_reset, reset_external;
  int                  bad_count, n_compared, n;

  // small counts keep the run short: 16/64/256/1024 and 64, same 4x steps
  rwcm_top #(.PWD_TO_2P15(22'h000010), .PWD_TO_2P17(22'h000040),
    .PWD_TO_2P19(22'h000100), .PWD_TO_2P21(22'h000400), .FWD_TO(22'h000040)) i_rwcm_top (
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rst_pin_i(rst_pin),
    .rst_pin_o(rst_pin_d), .rst_pin_oe(rst_pin_oe), .fixed_watchdog_option(fwd_opt),
    .option_byte_one(opt_byte), .bootloader_mode(boot), .clock_slow(clk_slow),
    .clock_absent(clk_absent), .stop_req(stop_req), .sys_reset(sys_reset),
    .reset_external(reset_external));
  rwcm_pin_model i_rwcm_pin_model (.clk(clk), .dev_oe(rst_pin_oe), .pin(rst_pin));

  // bus clock far above the monitor's lower limit
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rchk(input string w, input logic [12:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(w, e, reg_rdata);
  endtask
  task automatic wait_rst(input logic v, input int lim);
    n = 0;
    while (sys_reset !== v && n < lim)
    begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // watchdog: whole run needs about 12000 cycles
  initial
  begin
    repeat (30000) @(posedge clk);
    bad_count++;
    give_verdict();
  end

  initial
  begin
    reset_n = 1'b0;
    reg_addr = 13'h0000;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    fwd_opt = 1'b0;
    boot = 1'b0;
    clk_slow = 1'b0;
    clk_absent = 1'b0;
    stop_req = 1'b0;
    opt_byte = 8'h5A;
    bad_count = 0;
    n_compared = 0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    wait_rst(1'b0, 5000);
    chk("por length", 8'h01, {7'h00, (n >= 4064 && n <= 4072)});
    rchk("control reset", `RWCM_CONTROL_ADDR, 8'h00);
    rchk("option read", `RWCM_FIXED_ADDR, 8'h5A);
    rchk("unmapped read", 13'h0100, 8'h00);
    wr(`RWCM_CONTROL_ADDR, 8'hE7);
    opt_byte <= 8'hA5;
    rchk("first write", `RWCM_CONTROL_ADDR, 8'h07);
    wr(`RWCM_CONTROL_ADDR, 8'h08);
    rchk("monitor set, lock", `RWCM_CONTROL_ADDR, 8'h0F);
    wr(`RWCM_CONTROL_ADDR, 8'h00);
    rchk("monitor clear", `RWCM_CONTROL_ADDR, 8'h07);
    rchk("option follows", `RWCM_FIXED_ADDR, 8'hA5);
    $display("register test done");
    repeat (4)
    begin
      repeat (60) @(posedge clk);
      wr(`RWCM_SERVICE_ADDR, 8'h55);
      rchk("access between", `RWCM_CONTROL_ADDR, 8'h07);
      wr(`RWCM_SERVICE_ADDR, 8'hAA);
    end
    #1;
    chk("serviced", 8'h00, {7'h00, sys_reset});
    wr(`RWCM_SERVICE_ADDR, 8'hAA);
    wait_rst(1'b1, 1100);
    chk("lone second write", 8'h01, {7'h00, (n >= 1010 && n <= 1030)});
    wait_rst(1'b0, 50);
    rchk("flag after timeout", `RWCM_CONTROL_ADDR, 8'h10);
    rchk("flag read clears", `RWCM_CONTROL_ADDR, 8'h00);
    chk("internal class", 8'h00, {7'h00, reset_external});
    for (int s = 0; s < 4; s++)
    begin
      wr(`RWCM_CONTROL_ADDR, 8'h04 | {6'h00, s[1:0]});
      wait_rst(1'b1, 1100);
      chk("period", 8'h01, {7'h00, (n >= (16 << 2 * s) - 3 && n <= (16 << 2 * s) + 4)});
      wait_rst(1'b0, 50);
    end
    $display("programmable watchdog test done");
    @(posedge clk);
    boot <= 1'b1;
    fwd_opt <= 1'b1;
    repeat (200) @(posedge clk);
    #1;
    chk("bootloader off", 8'h00, {7'h00, sys_reset});
    @(posedge clk);
    boot <= 1'b0;
    wait_rst(1'b1, 100);
    chk("fixed period", 8'h01, {7'h00, (n >= 60 && n <= 72)});
    wait_rst(1'b0, 50);
    repeat (4)
    begin
      repeat (40) @(posedge clk);
      wr(`RWCM_FIXED_ADDR, 8'hFE);
    end
    #1;
    chk("fixed serviced", 8'h00, {7'h00, sys_reset});
    wr(`RWCM_CONTROL_ADDR, 8'h04);
    wait_rst(1'b1, 30);
    chk("both running", 8'h01, {7'h00, (n <= 20)});
    @(posedge clk);
    fwd_opt <= 1'b0;
    wait_rst(1'b0, 50);
    rchk("flag before monitor", `RWCM_CONTROL_ADDR, 8'h10);
    repeat (150) @(posedge clk);
    #1;
    chk("option clear", 8'h00, {7'h00, sys_reset});
    $display("fixed watchdog test done");
    @(posedge clk);
    clk_slow <= 1'b1;
    repeat (10) @(posedge clk);
    #1;
    chk("monitor off", 8'h00, {7'h00, sys_reset});
    @(posedge clk);
    clk_slow <= 1'b0;
    for (int k = 0; k < 3; k++)
    begin
      wr(`RWCM_CONTROL_ADDR, 8'h08);
      clk_slow <= (k == 0);
      stop_req <= (k == 1);
      clk_absent <= (k == 2);
      wait_rst(1'b1, 10);
      chk("monitor reset", 8'h01, {7'h00, sys_reset});
      repeat (20) @(posedge clk);
      #1;
      chk("pin drive", {7'h00, (k == 2)}, {7'h00, rst_pin_oe});
      chk("pin data", 8'h00, {7'h00, rst_pin_d});
      @(posedge clk);
      clk_slow <= 1'b0;
      stop_req <= 1'b0;
      clk_absent <= 1'b0;
      wait_rst(1'b0, 50);
      rchk("monitor flag", `RWCM_CONTROL_ADDR, 8'h10);
    end
    $display("clock monitor test done");
    i_rwcm_pin_model.drive_low(12);
    wait_rst(1'b0, 50);
    chk("external class", 8'h01, {7'h00, reset_external});
    i_rwcm_pin_model.drive_low(2);
    wait_rst(1'b1, 10);
    chk("short pulse", 8'h01, {7'h00, sys_reset});
    wait_rst(1'b0, 50);
    chk("short pulse class", 8'h00, {7'h00, reset_external});
    $display("external reset test done");
    i_rwcm_pin_model.hold(1'b1);
    reset_n <= 1'b0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4100) @(posedge clk);
    #1;
    chk("pin extends por", 8'h01, {7'h00, sys_reset});
    i_rwcm_pin_model.hold(1'b0);
    wait_rst(1'b0, 20);
    chk("por released", 8'h00, {7'h00, sys_reset});
    $display("power-on test done");
    give_verdict();
  end
endmodule // rwcm_top_tb
`default_nettype wire
